// File: hdl/stale_timer_and_port_regs.v
// Function
// - Stale timer runs and acts only in the receive direction.
// - Each character stored in the FIFO reloads count from period, restarts.
// - Count reaching zero sets the stale flag, status bit 2.
// - Stale with a whole word available requests DMA of remaining words.
// - After stale DMA, one leftover character raises a host interrupt.
// - Device reset and FIFO reset both clear the timer count.
// - Software writing zero to the count sets stale at once.
// - Clock divided to 10 us, then by ten to 0.1 ms ticks.
// - Prescaler restarts on reload, one tick lasts 0.09 to 0.1 ms.
// - Period is an 8-bit tick count, up to 255 ticks.
// - Device reset clears the timer period.
// - EPP address write from the host captures the address byte.
// - EPP address read returns the held address byte.
// - Pin view shows live handshake pins in bits 3:0, zeros above.
// - Manual data read returns the live data lines in any mode.
// - Manual byte drives lines only with manual mode, direction, enable.
// - Negotiation permitted only with protocol bit and master enable set.
// - Mask bits: 6 id, 4 EPP, 3 RLE, 2 ECP, 1 byte, 0 nibble.
// - No ID string is stored or sent by the hardware.
// - Slave ID requests are not offered when negotiating into EPP.
// - Stale with one byte left raises interrupt, flag, holds pipeline.
`timescale 1ns/100ps
`include "stale_timer_and_port_regs.vh"

module stale_timer_and_port_regs
#(
    parameter INTER_DIV = `INTER_DIV,
    parameter PRESCALE  = `TICK_PRESCALE
)
(
    input  wire        clk,
    input  wire        rst,
    input  wire [9:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    input  wire        rx_direction,
    input  wire        fifo_reset,
    input  wire        rx_char_stored,
    input  wire        words_available,
    input  wire        one_byte_left,
    input  wire        dma_busy,
    input  wire        holding2_read,
    input  wire        epp_mode,
    input  wire        epp_addr_write,
    input  wire [7:0]  epp_addr_in,
    output reg  [7:0]  epp_addr_out,
    input  wire        host_ieee_active_in,
    input  wire        host_reinit_low,
    input  wire        host_busy_in,
    input  wire        host_strobe_in,
    input  wire [7:0]  parallel_data_lines_in,
    output reg  [7:0]  parallel_data_lines_out,
    output reg         parallel_data_lines_oe,
    input  wire        nego_target_epp,
    output reg  [7:0]  neg_allow,
    output reg         stale_flag,
    output reg         dma_request,
    output reg         host_irq,
    output reg         single_leftover_flag,
    output reg         pipeline_hold
);

////////////////////////////////////////////////////////////////////////////
// Decode helper: word index of a byte address
function is_reg;
    input [9:0] addr;
    input [7:0] idx;
    begin
        is_reg = (addr[9:2] == idx);
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Register storage
reg [7:0] idle_timer_period;
reg [7:0] idle_timer_count;
reg [7:0] negotiation_enable_mask;
reg [7:0] port_control_reg;
reg [7:0] manual_line_data;
reg [7:0] rd_byte;

wire [3:0] pins_live;
wire [7:0] lines_live;
wire       tick;

////////////////////////////////////////////////////////////////////////////
// Bus handshake: accept on one edge, complete on the next
// A write lands only at the edge where the master sees waitrequest low
wire req    = read | write;
wire accept = req & waitrequest;
wire commit = write & ~waitrequest & byteenable[0];

wire wr_period = commit & is_reg(address, `IDX_IDLE_TIMER_PERIOD);
wire wr_count  = commit & is_reg(address, `IDX_IDLE_TIMER_COUNT);
wire wr_epp    = commit & is_reg(address, `IDX_EPP_ADDRESS_HOLD);
wire wr_mask   = commit & is_reg(address, `IDX_NEGOTIATION_MASK);
wire wr_ctrl   = commit & is_reg(address, `IDX_PORT_CONTROL);
wire wr_manual = commit & is_reg(address, `IDX_MANUAL_LINE_DATA);

////////////////////////////////////////////////////////////////////////////
// Timer events
// Ticks are ignored in transmit, so the count freezes there
// Expiry: reload with period zero, or the last tick taking count 1 to 0
wire reload    = rx_direction & rx_char_stored;
wire count_dec = rx_direction & tick & (idle_timer_count != 8'h00);
wire expire    = ~wr_count &
                 ((reload & (idle_timer_period == 8'h00)) |
                  (~reload & count_dec & (idle_timer_count == 8'h01)));
wire sw_zero   = wr_count & (writedata[7:0] == 8'h00);
wire restart   = reload | wr_count;

////////////////////////////////////////////////////////////////////////////
// Leftover and DMA conditions
// The odd byte waits until DMA has drained every whole word
wire leftover_set = rx_direction & stale_flag & one_byte_left &
                    ~words_available & ~dma_busy;
reg  next_leftover;

always @*
begin
    next_leftover = single_leftover_flag;
    if (fifo_reset)
        next_leftover = 1'b0;
    else if (leftover_set)
        next_leftover = 1'b1;
    else if (holding2_read)
        next_leftover = 1'b0;
end

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and tick divider
// Data lines share the filter, so manual reads only see settled values
pin_sync
#(
    .W (4)
)
u_handshake_sync
(
    .clk   (clk),
    .rst   (rst),
    .pin   ({host_ieee_active_in, host_reinit_low,
             host_busy_in, host_strobe_in}),
    .level (pins_live)
);

pin_sync
#(
    .W (8)
)
u_lines_sync
(
    .clk   (clk),
    .rst   (rst),
    .pin   (parallel_data_lines_in),
    .level (lines_live)
);

stale_tick_gen
#(
    .INTER_DIV (INTER_DIV),
    .PRESCALE  (PRESCALE)
)
u_tick
(
    .clk     (clk),
    .rst     (rst),
    .restart (restart),
    .tick    (tick)
);

////////////////////////////////////////////////////////////////////////////
// Period register, cleared only by device reset
always @(posedge clk)
begin
    if (rst)
        idle_timer_period <= `RST_BYTE;
    else if (wr_period)
        idle_timer_period <= writedata[7:0];
end

// Down counter; software write wins, then reload, then tick
// A tick with the count already zero does nothing, so it never wraps
always @(posedge clk)
begin
    if (rst || fifo_reset)
        idle_timer_count <= `RST_BYTE;
    else if (wr_count)
        idle_timer_count <= writedata[7:0];
    else if (reload)
        idle_timer_count <= idle_timer_period;
    else if (count_dec)
        idle_timer_count <= idle_timer_count - 8'h01;
end

// Stale flag; a set in the same cycle as a reload wins
always @(posedge clk)
begin
    if (rst || fifo_reset)
        stale_flag <= 1'b0;
    else if (expire || sw_zero)
        stale_flag <= 1'b1;
    else if (reload)
        stale_flag <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////
// DMA request and leftover interrupt outputs
// Registered from level inputs: one cycle late but free of glitches
always @(posedge clk)
begin
    if (rst)
    begin
        dma_request          <= 1'b0;
        single_leftover_flag <= 1'b0;
        host_irq             <= 1'b0;
        pipeline_hold        <= 1'b0;
    end
    else
    begin
        dma_request          <= rx_direction & stale_flag &
                                words_available & ~fifo_reset;
        single_leftover_flag <= next_leftover;
        host_irq             <= next_leftover;
        pipeline_hold        <= next_leftover;
    end
end

////////////////////////////////////////////////////////////////////////////
// EPP address hold; host capture in EPP mode, software may also write
// Host capture wins over a software write in the same cycle
always @(posedge clk)
begin
    if (rst)
        epp_addr_out <= `RST_BYTE;
    else if (epp_mode && epp_addr_write)
        epp_addr_out <= epp_addr_in;
    else if (wr_epp)
        epp_addr_out <= writedata[7:0];
end

////////////////////////////////////////////////////////////////////////////
// Negotiation mask and port control; reserved bits never stored
// Control bits 5:2 are reserved, so they always read back zero
always @(posedge clk)
begin
    if (rst)
    begin
        negotiation_enable_mask <= `RST_BYTE;
        port_control_reg        <= `RST_BYTE;
        manual_line_data        <= `RST_BYTE;
    end
    else
    begin
        if (wr_mask)
            negotiation_enable_mask <= writedata[7:0] &
                                       `NEG_WRITE_MASK;
        if (wr_ctrl)
            port_control_reg <= writedata[7:0] & `PCR_WRITE_MASK;
        if (wr_manual)
            manual_line_data <= writedata[7:0];
    end
end

// Permission per protocol; the ID string itself is left to software
// One cycle behind the registers, far quicker than any negotiation
always @(posedge clk)
begin
    if (rst)
        neg_allow <= 8'h00;
    else
    begin
        neg_allow <= negotiation_enable_mask &
                     {8{port_control_reg[`PCR_MASTER_ENABLE_BIT]}};
        if (nego_target_epp)
            neg_allow[`NEG_SLAVE_ID_BIT] <= 1'b0;
    end
end

// Manual drive of the data lines, all three control bits required
// The byte follows the register even while the lines are not driven
always @(posedge clk)
begin
    if (rst)
    begin
        parallel_data_lines_out <= 8'h00;
        parallel_data_lines_oe  <= 1'b0;
    end
    else
    begin
        parallel_data_lines_out <= manual_line_data;
        parallel_data_lines_oe  <=
            port_control_reg[`PCR_MANUAL_MODE_BIT] &
            port_control_reg[`PCR_MANUAL_DIR_BIT] &
            port_control_reg[`PCR_MANUAL_OE_BIT];
    end
end

////////////////////////////////////////////////////////////////////////////
// Read multiplexer; unmapped words read zero
// Live views come from the synchronisers, never from the raw pins
always @*
begin
    rd_byte = 8'h00;
    case (address[9:2])
        `IDX_EPP_ADDRESS_HOLD:   rd_byte = epp_addr_out;
        `IDX_NEGOTIATION_MASK:   rd_byte = negotiation_enable_mask;
        `IDX_PORT_CONTROL:       rd_byte = port_control_reg;
        `IDX_HANDSHAKE_PIN_VIEW: rd_byte = {4'h0, pins_live};
        `IDX_MANUAL_LINE_DATA:   rd_byte = lines_live;
        `IDX_FIFO_STATUS:
            rd_byte = {5'h00, stale_flag, single_leftover_flag, 1'b0};
        `IDX_IDLE_TIMER_PERIOD:  rd_byte = idle_timer_period;
        `IDX_IDLE_TIMER_COUNT:   rd_byte = idle_timer_count;
        default:                 rd_byte = 8'h00;
    endcase
end

// Slave answer: waitrequest drops for exactly one cycle per request
// Read data is latched at acceptance and stands until the next one
always @(posedge clk)
begin
    if (rst)
    begin
        waitrequest <= 1'b1;
        readdata    <= 32'h00000000;
    end
    else if (accept)
    begin
        waitrequest <= 1'b0;
        readdata    <= read ? {24'h000000, rd_byte} : 32'h00000000;
    end
    else
        waitrequest <= 1'b1;
end

endmodule // stale_timer_and_port_regs

// File: inc/stale_timer_and_port_regs.vh
`ifndef STALE_TIMER_AND_PORT_REGS_VH
`define STALE_TIMER_AND_PORT_REGS_VH

////////////////////////////////////////////////////////////////////////////
// Register indexes, byte address is four times the index
`define IDX_EPP_ADDRESS_HOLD     8'h25
`define IDX_NEGOTIATION_MASK     8'h28
`define IDX_PORT_CONTROL         8'h2a
`define IDX_HANDSHAKE_PIN_VIEW   8'h2e
`define IDX_MANUAL_LINE_DATA     8'h2f
`define IDX_FIFO_STATUS          8'h38
`define IDX_IDLE_TIMER_PERIOD    8'h3c
`define IDX_IDLE_TIMER_COUNT     8'h3d

////////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_BYTE                 8'h00

////////////////////////////////////////////////////////////////////////////
// Field positions
`define FSR_STALE_BIT            2
`define FSR_LEFTOVER_BIT         1
`define PCR_MANUAL_MODE_BIT      7
`define PCR_MASTER_ENABLE_BIT    6
`define PCR_MANUAL_DIR_BIT       1
`define PCR_MANUAL_OE_BIT        0
`define PCR_WRITE_MASK           8'hc3
`define NEG_SLAVE_ID_BIT         6
`define NEG_RESERVED_BIT         5
`define NEG_EPP_BIT              4
`define NEG_RLE_BIT              3
`define NEG_ECP_BIT              2
`define NEG_REV_BYTE_BIT         1
`define NEG_REV_NIBBLE_BIT       0
`define NEG_WRITE_MASK           8'h5f

////////////////////////////////////////////////////////////////////////////
// Timing: reference clock and divide, converted to this clock's rate
`define REF_CLK_MHZ              25
`define REF_CLK_DIV              250
`define CLK_PERIOD_NS            4
`define INTER_PERIOD_NS          (`REF_CLK_DIV * 1000 / `REF_CLK_MHZ)
`define INTER_DIV                (`INTER_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_PRESCALE            10

`endif

// File: hdl/pin_sync.v
`timescale 1ns/100ps
`include "stale_timer_and_port_regs.vh"

module pin_sync
#(
    parameter W = 4
)
(
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] pin,
    output reg  [W-1:0] level
);

////////////////////////////////////////////////////////////////////////////
reg [W-1:0] stage1;
reg [W-1:0] stage2;
reg [W-1:0] stage3;
integer     i;

// Three flops; a bit moves only once the last two stages agree
always @(posedge clk)
begin
    if (rst)
    begin
        stage1 <= {W{1'b0}};
        stage2 <= {W{1'b0}};
        stage3 <= {W{1'b0}};
        level  <= {W{1'b0}};
    end
    else
    begin
        stage1 <= pin;
        stage2 <= stage1;
        stage3 <= stage2;
        for (i = 0; i < W; i = i + 1)
        begin
            if (stage2[i] == stage3[i])
                level[i] <= stage3[i];
        end
    end
end

endmodule // pin_sync

// File: hdl/stale_tick_gen.v
`timescale 1ns/100ps
`include "stale_timer_and_port_regs.vh"

module stale_tick_gen
#(
    parameter INTER_DIV = `INTER_DIV,
    parameter PRESCALE  = `TICK_PRESCALE
)
(
    input  wire clk,
    input  wire rst,
    input  wire restart,
    output reg  tick
);

////////////////////////////////////////////////////////////////////////////
reg [11:0] inter_cnt;
reg [3:0]  pre_cnt;
reg        inter_pulse;

// Free running 10 us divider; never restarted, hence the 0.09..0.1 ms
always @(posedge clk)
begin
    if (rst)
    begin
        inter_cnt   <= 12'h000;
        inter_pulse <= 1'b0;
    end
    else if (inter_cnt == INTER_DIV[11:0] - 12'h001)
    begin
        inter_cnt   <= 12'h000;
        inter_pulse <= 1'b1;
    end
    else
    begin
        inter_cnt   <= inter_cnt + 12'h001;
        inter_pulse <= 1'b0;
    end
end

// Divide-by-ten prescaler, cleared on every timer reload
always @(posedge clk)
begin
    if (rst)
    begin
        pre_cnt <= 4'h0;
        tick    <= 1'b0;
    end
    else if (restart)
    begin
        pre_cnt <= 4'h0;
        tick    <= 1'b0;
    end
    else if (inter_pulse)
    begin
        if (pre_cnt == PRESCALE[3:0] - 4'h1)
        begin
            pre_cnt <= 4'h0;
            tick    <= 1'b1;
        end
        else
        begin
            pre_cnt <= pre_cnt + 4'h1;
            tick    <= 1'b0;
        end
    end
    else
        tick <= 1'b0;
end

endmodule // stale_tick_gen

// File: tb/host_port_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Host end of the link: handshake pins and the shared data lines
module host_port_model
(
    input  wire       clk,
    input  wire [3:0] pin_cmd,
    input  wire       host_drive,
    input  wire [7:0] host_byte,
    input  wire [7:0] dev_byte,
    input  wire       dev_oe,
    output reg  [3:0] pins = 4'h0,
    output wire [7:0] lines
);
    reg [7:0] float_val = 8'h00;

    // Pins move just after an edge, unrelated to the device's sampling
    always @(posedge clk)
        pins <= pin_cmd;

    // Nobody driving: lines wander so a stale value never looks valid
    always @(posedge clk)
        float_val <= ~lines;

    // Device wins if both drive; the bench never lets that happen
    assign lines = dev_oe ? dev_byte : host_drive ? host_byte : float_val;
endmodule // host_port_model

// File: tb/stale_timer_and_port_regs_sva.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Port-level checks of the stale timer and port register block
module stale_regs_checker
(
    input wire        clk,
    input wire        rst,
    input wire        read,
    input wire        write,
    input wire [31:0] readdata,
    input wire        waitrequest,
    input wire        rx_direction,
    input wire        fifo_reset,
    input wire        words_available,
    input wire        one_byte_left,
    input wire        dma_busy,
    input wire        epp_mode,
    input wire        epp_addr_write,
    input wire [7:0]  epp_addr_in,
    input wire [7:0]  epp_addr_out,
    input wire        nego_target_epp,
    input wire [7:0]  neg_allow,
    input wire        stale_flag,
    input wire        dma_request,
    input wire        host_irq,
    input wire        single_leftover_flag,
    input wire        pipeline_hold
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Bus answers with exactly one wait state, low for one cycle
    chk_bus_answer: assert property ((read || write) && waitrequest
        |=> !waitrequest ##1 waitrequest) else $error("bus answer late");
    chk_read_upper: assert property (readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_dma_raise: assert property (
        rx_direction && stale_flag && words_available && !fifo_reset
        |=> dma_request) else $error("no dma request on stale");
    chk_dma_tx_quiet: assert property (!rx_direction |=> !dma_request)
        else $error("dma request in transmit");
    chk_tx_no_stale: assert property (
        !rx_direction && !write |=> !$rose(stale_flag))
        else $error("stale rose in transmit");
    chk_leftover_set: assert property (rx_direction && stale_flag
        && one_byte_left && !words_available && !dma_busy && !fifo_reset
        |=> single_leftover_flag) else $error("leftover not flagged");
    chk_irq_mirror: assert property (host_irq == single_leftover_flag
        && pipeline_hold == single_leftover_flag)
        else $error("irq and hold disagree with flag");
    chk_fifo_clear: assert property (
        fifo_reset |=> !stale_flag && !single_leftover_flag)
        else $error("fifo reset left flags set");
    chk_epp_capture: assert property (epp_mode && epp_addr_write
        |=> epp_addr_out == $past(epp_addr_in))
        else $error("epp address not captured");
    chk_epp_keep: assert property (
        !(epp_mode && epp_addr_write) && !write
        |=> $stable(epp_addr_out)) else $error("epp address drifted");
    chk_no_epp_id: assert property (nego_target_epp |=> !neg_allow[6])
        else $error("id permit during epp");
    chk_neg_reserved: assert property (neg_allow[7] == 1'h0
        && neg_allow[5] == 1'h0) else $error("reserved permit bit set");
endmodule // stale_regs_checker

bind stale_timer_and_port_regs stale_regs_checker i_stale_regs_checker
(
    .clk, .rst, .read, .write, .readdata, .waitrequest, .rx_direction,
    .fifo_reset, .words_available, .one_byte_left, .dma_busy, .epp_mode,
    .epp_addr_write, .epp_addr_in, .epp_addr_out, .nego_target_epp,
    .neg_allow, .stale_flag, .dma_request, .host_irq,
    .single_leftover_flag, .pipeline_hold
);

// File: tb/stale_timer_and_port_regs_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t: got %h want %h", $time, a, b); end end
module stale_timer_and_port_regs_bench;
    reg         clk = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0;
    reg         rx_direction = 1'h1, fifo_reset = 1'h0, rx_char_stored = 1'h0;
    reg         words_available = 1'h0, one_byte_left = 1'h0, dma_busy = 1'h0;
    reg         holding2_read = 1'h0, epp_mode = 1'h0, epp_addr_write = 1'h0;
    reg         nego_target_epp = 1'h0, host_drive = 1'h1;
    reg  [9:0]  address = 10'h000;
    reg  [31:0] writedata = 32'h0;
    reg  [3:0]  byteenable = 4'h1, pin_cmd = 4'h0;
    reg  [7:0]  epp_addr_in = 8'h00, host_byte = 8'h00, v, m;
    wire [31:0] readdata;
    wire [7:0]  epp_addr_out, dev_byte, neg_allow, lines;
    wire [3:0]  pins;
    wire        waitrequest, dev_oe, stale_flag, dma_request, host_irq;
    wire        single_leftover_flag, pipeline_hold;
    int         fails = 0, total_checks = 0, n, p;
    logic [7:0] exp_q[$];
    logic [7:0] exp_byte;

    // Short divide so one tick is 40 clocks instead of 25000
    stale_timer_and_port_regs #(.INTER_DIV(4), .PRESCALE(10))
        i_stale_timer_and_port_regs
    (
        .clk, .rst, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .rx_direction, .fifo_reset, .rx_char_stored,
        .words_available, .one_byte_left, .dma_busy, .holding2_read,
        .epp_mode, .epp_addr_write, .epp_addr_in, .epp_addr_out,
        .host_ieee_active_in(pins[3]), .host_reinit_low(pins[2]),
        .host_busy_in(pins[1]), .host_strobe_in(pins[0]),
        .parallel_data_lines_in(lines), .parallel_data_lines_out(dev_byte),
        .parallel_data_lines_oe(dev_oe), .nego_target_epp, .neg_allow,
        .stale_flag, .dma_request, .host_irq, .single_leftover_flag,
        .pipeline_hold
    );

    host_port_model i_host_port_model
    (
        .clk, .pin_cmd, .host_drive, .host_byte, .dev_byte, .dev_oe, .pins,
        .lines
    );

    // 250 MHz
    always #2 clk = ~clk;

    // Read answers arrive in request order, so the oldest note matches
    always @(posedge clk)
        if (read && !waitrequest)
        begin
            exp_byte = exp_q.pop_front();
            `CHK(readdata, {24'h0, exp_byte})
        end

    ////////////////////////////////////////////////////////////////////////
    // One bus access; a read leaves its expected byte in the queue
    task automatic bus(input bit wr, input [7:0] idx, input [7:0] wd);
        @(posedge clk);
        address <= {idx, 2'h0};
        writedata <= {24'h0, wd};
        write <= wr;
        read <= !wr;
        if (!wr)
            exp_q.push_back(wd);
        @(posedge clk);
        while (waitrequest)
            @(posedge clk);
        read <= 1'h0;
        write <= 1'h0;
    endtask

    task give_verdict;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Whole run is under 2000 clocks; this cuts a hang well after that
    initial
    begin
        #40000;
        fails++;
        give_verdict;
    end

    initial
    begin
        n = $urandom(32'h7027);
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        bus(0, 8'h25, 8'h00);
        bus(0, 8'h28, 8'h00);
        bus(0, 8'h3c, 8'h00);
        bus(0, 8'h3d, 8'h00);
        bus(0, 8'h01, 8'h00);
        // Random period; reload lands at a fixed divider phase and clears the prescaler
        p = $urandom_range(4, 1);
        bus(1, 8'h3c, p[7:0]);
        bus(0, 8'h3c, p[7:0]);
        @(posedge clk) rx_char_stored <= 1'h1;
        @(posedge clk) rx_char_stored <= 1'h0;
        repeat (40 * p - 6) @(posedge clk);
        `CHK(stale_flag, 1'h0)
        for (n = 0; n < 12 && stale_flag !== 1'h1; n++)
            @(posedge clk);
        `CHK(stale_flag, 1'h1)
        repeat (60) @(posedge clk);
        bus(0, 8'h3d, 8'h00);
        // Whole words go by DMA; the odd byte waits for DMA to finish
        words_available <= 1'h1;
        repeat (3) @(posedge clk);
        `CHK(dma_request, 1'h1)
        words_available <= 1'h0;
        one_byte_left <= 1'h1;
        dma_busy <= 1'h1;
        repeat (3) @(posedge clk);
        `CHK(host_irq, 1'h0)
        dma_busy <= 1'h0;
        repeat (3) @(posedge clk);
        `CHK(host_irq, 1'h1)
        `CHK(single_leftover_flag, 1'h1)
        `CHK(pipeline_hold, 1'h1)
        one_byte_left <= 1'h0;
        holding2_read <= 1'h1;
        @(posedge clk) holding2_read <= 1'h0;
        repeat (2) @(posedge clk);
        `CHK(host_irq, 1'h0)
        // Transmit: a stored character must not reload or clear stale
        rx_direction <= 1'h0;
        bus(1, 8'h3d, 8'h55);
        @(posedge clk) rx_char_stored <= 1'h1;
        @(posedge clk) rx_char_stored <= 1'h0;
        repeat (100) @(posedge clk);
        bus(0, 8'h3d, 8'h55);
        `CHK(stale_flag, 1'h1)
        rx_direction <= 1'h1;
        @(posedge clk) fifo_reset <= 1'h1;
        @(posedge clk) fifo_reset <= 1'h0;
        bus(0, 8'h3d, 8'h00);
        `CHK(stale_flag, 1'h0)
        bus(0, 8'h3c, p[7:0]);
        bus(1, 8'h3d, 8'h00);
        @(posedge clk);
        `CHK(stale_flag, 1'h1)
        // Negotiation permits; software keeps mask bit 5 clear
        m = 8'($urandom) & 8'hdf;
        bus(1, 8'h28, m);
        bus(0, 8'h28, m & 8'h5f);
        `CHK(neg_allow, 8'h00)
        bus(1, 8'h2a, 8'h40);
        repeat (2) @(posedge clk);
        `CHK(neg_allow, m & 8'h5f)
        nego_target_epp <= 1'h1;
        repeat (2) @(posedge clk);
        `CHK(neg_allow, m & 8'h1f)
        // Live pins and data lines, then the manual drive
        v = 8'($urandom);
        pin_cmd <= v[3:0];
        host_byte <= v;
        repeat (8) @(posedge clk);
        bus(0, 8'h2e, {4'h0, v[3:0]});
        bus(0, 8'h2f, v);
        bus(1, 8'h2f, ~v);
        host_drive <= 1'h0;
        bus(1, 8'h2a, 8'hc3);
        repeat (2) @(posedge clk);
        `CHK(dev_oe, 1'h1)
        `CHK(dev_byte, ~v)
        repeat (6) @(posedge clk);
        bus(0, 8'h2f, ~v);
        bus(1, 8'h2a, 8'hc1);
        repeat (2) @(posedge clk);
        `CHK(dev_oe, 1'h0)
        // Host address writes count only in EPP mode
        epp_mode <= 1'h1;
        epp_addr_in <= v;
        epp_addr_write <= 1'h1;
        @(posedge clk) epp_addr_write <= 1'h0;
        epp_mode <= 1'h0;
        bus(0, 8'h25, v);
        `CHK(epp_addr_out, v)
        epp_addr_in <= ~v;
        epp_addr_write <= 1'h1;
        @(posedge clk) epp_addr_write <= 1'h0;
        bus(0, 8'h25, v);
        `CHK(epp_addr_out, v)
        // A write without byte lane 0 is answered but stores nothing
        byteenable <= 4'he;
        bus(1, 8'h25, ~v);
        byteenable <= 4'h1;
        bus(0, 8'h25, v);
        give_verdict;
    end
endmodule // stale_timer_and_port_regs_bench
